// file: rtl/aux_timer_pkg.sv
// constants, field layout and types of the auxiliary timer block
//
// Contract
// - mode field selects timer, counter, gated modes
// - run bit halts or allows counting
// - trigger source: capture pin or third timer
// - trigger edge field selects capture edges
// - optional timer clear on each capture
// - capture enable gates latching into capture register
// - counter clocked by pin or core toggle latch
// - input select picks count pin edges
// - input select picks toggle latch edges
// - software toggle latch changes never count
// - count pin edges detected up to clock/8
// - no toggle latch, no pin output here
// - timer modes behave like core timer
// - direction bits act like core timer bits
// - control register layout, resets to zero
// - prescaler divides clock by 4 to 512
// - gated mode needs run and active gate
// - wrap sets the overflow request flag
package aux_timer_pkg;

   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DATA_W     = 16;
   localparam int unsigned PRESC_W    = 9;
   localparam int unsigned TICK_BASE  = 4;

   localparam logic [ADDR_W-1:0] CTRL_ADDR  = 16'hFF46;
   localparam logic [ADDR_W-1:0] TIMER_ADDR = 16'hFF48;
   localparam logic [ADDR_W-1:0] CAPT_ADDR  = 16'hFF4A;
   localparam logic [ADDR_W-1:0] STAT_ADDR  = 16'hFF4C;

   localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0] CTRL_WMASK  = 16'hF5FF;
   localparam logic [DATA_W-1:0] TIMER_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CAPT_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0] READ_IDLE   = 16'h0000;
   localparam logic [PRESC_W-1:0] PRESC_RESET = 9'h000;

   localparam int unsigned STAT_OVF_BIT  = 0;
   localparam int unsigned STAT_CAPT_BIT = 1;

   // edge detector lane positions
   localparam int unsigned EDGE_COUNT_PIN  = 0;
   localparam int unsigned EDGE_CAPT_PIN   = 1;
   localparam int unsigned EDGE_T3_COUNT   = 2;
   localparam int unsigned EDGE_T3_DIR     = 3;
   localparam int unsigned EDGE_TOGGLE     = 4;
   localparam int unsigned EDGE_NUM        = 5;

   typedef enum logic [2:0] {
      MODE_TIMER     = 3'b000,
      MODE_COUNTER   = 3'b001,
      MODE_GATE_LOW  = 3'b010,
      MODE_GATE_HIGH = 3'b011
   } aux_mode_type;

   typedef struct packed {
      logic       capture_enable;
      logic       clear_on_capture;
      logic [1:0] capture_edge_select;
      logic       unused_11;
      logic       capture_source_select;
      logic       unused_9;
      logic       aux_ext_direction_enable;
      logic       aux_up_down_bit;
      logic       aux_run_bit;
      logic [2:0] aux_mode_field;
      logic [2:0] aux_input_select;
   } aux_ctrl_type;

   typedef struct packed {
      logic rise;
      logic fall;
   } edge_pair_type;

endpackage : aux_timer_pkg

// file: rtl/edge_detect.sv
// one-cycle rise and fall detection on a group of synchronous inputs
`timescale 1ns/10ps
`default_nettype none

module edge_detect #(
   parameter int unsigned WIDTH = 5
) (
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] sig_i,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o
);

   logic [WIDTH-1:0] prev_q;

   // follow the inputs during reset so release gives no false edge
   always_ff @(posedge mclk_i) begin
      prev_q <= sig_i;
   end

   assign rise_o = nrst_i ? (sig_i & ~prev_q) : '0;
   assign fall_o = nrst_i ? (~sig_i & prev_q) : '0;

endmodule : edge_detect

`default_nettype wire

// file: rtl/aux_timer_control.sv
// auxiliary up/down timer with capture control and register port
`timescale 1ns/10ps
`default_nettype none

module aux_timer_control (
   input  wire logic                              mclk_i,
   input  wire logic                              nrst_i,
   input  wire logic [aux_timer_pkg::ADDR_W-1:0]  reg_addr_i,
   input  wire logic [aux_timer_pkg::DATA_W-1:0]  reg_wdata_i,
   input  wire logic                              reg_wr_i,
   input  wire logic                              reg_rd_i,
   output logic      [aux_timer_pkg::DATA_W-1:0]  reg_rdata_o,
   input  wire logic                              aux_count_pin_i,
   input  wire logic                              aux_direction_pin_i,
   input  wire logic                              capture_pin_i,
   input  wire logic                              third_timer_count_input_i,
   input  wire logic                      third_timer_direction_input_i,
   input  wire logic                              core_toggle_latch_i,
   input  wire logic                              core_toggle_hw_i,
   output logic      [aux_timer_pkg::DATA_W-1:0]  aux_timer_o,
   output logic      [aux_timer_pkg::DATA_W-1:0]  capture_reload_reg_o,
   output logic                                   aux_overflow_flag_o,
   output logic                                   capture_flag_o,
   output logic                                   capture_event_o
);

   import aux_timer_pkg::*;

   function automatic logic presc_tick(
      input logic [PRESC_W-1:0] cnt,
      input logic [2:0]         sel
   );
      logic [PRESC_W-1:0] mask;
      mask = PRESC_W'((TICK_BASE << sel) - 1);
      return &(cnt | ~mask);
   endfunction : presc_tick

   // two-bit edge field: bit 0 picks the first event, bit 1 the second
   function automatic logic edge_hit(
      input logic [1:0] sel,
      input logic       first,
      input logic       second
   );
      return (sel[0] & first) | (sel[1] & second);
   endfunction : edge_hit

   aux_ctrl_type        ctrl_q;
   aux_ctrl_type        ctrl_d;
   logic [DATA_W-1:0]   timer_q;
   logic [DATA_W-1:0]   timer_d;
   logic [DATA_W-1:0]   capt_q;
   logic [DATA_W-1:0]   capt_d;
   logic [DATA_W-1:0]   rdata_q;
   logic [DATA_W-1:0]   rdata_d;
   logic [PRESC_W-1:0]  presc_q;
   logic                ovf_q;
   logic                ovf_d;
   logic                cflag_q;
   logic                cflag_d;
   logic                cevt_q;

   logic [EDGE_NUM-1:0] pins_s;
   logic [EDGE_NUM-1:0] rise_s;
   logic [EDGE_NUM-1:0] fall_s;

   assign pins_s[EDGE_COUNT_PIN] = aux_count_pin_i;
   assign pins_s[EDGE_CAPT_PIN]  = capture_pin_i;
   assign pins_s[EDGE_T3_COUNT]  = third_timer_count_input_i;
   assign pins_s[EDGE_T3_DIR]    = third_timer_direction_input_i;
   assign pins_s[EDGE_TOGGLE]    = core_toggle_latch_i;

   // single-stage compare catches every level held four clocks
   edge_detect #(
      .WIDTH (EDGE_NUM)
   ) u_edges (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .sig_i  (pins_s),
      .rise_o (rise_s),
      .fall_o (fall_s)
   );

   edge_pair_type pin_edge_s;
   edge_pair_type tog_edge_s;
   edge_pair_type cap_edge_s;

   assign pin_edge_s = '{rise: rise_s[EDGE_COUNT_PIN],
                         fall: fall_s[EDGE_COUNT_PIN]};
   // latch moves written by software carry no hardware qualifier
   assign tog_edge_s = '{rise: rise_s[EDGE_TOGGLE] & core_toggle_hw_i,
                         fall: fall_s[EDGE_TOGGLE] & core_toggle_hw_i};
   assign cap_edge_s = '{rise: rise_s[EDGE_CAPT_PIN],
                         fall: fall_s[EDGE_CAPT_PIN]};

   wire t3_count_any_s = rise_s[EDGE_T3_COUNT] | fall_s[EDGE_T3_COUNT];
   wire t3_dir_any_s   = rise_s[EDGE_T3_DIR] | fall_s[EDGE_T3_DIR];

   wire sel_ctrl_s  = (reg_addr_i == CTRL_ADDR);
   wire sel_timer_s = (reg_addr_i == TIMER_ADDR);
   wire sel_capt_s  = (reg_addr_i == CAPT_ADDR);
   wire sel_stat_s  = (reg_addr_i == STAT_ADDR);

   wire wr_ctrl_s  = reg_wr_i & sel_ctrl_s;
   wire wr_timer_s = reg_wr_i & sel_timer_s;
   wire wr_capt_s  = reg_wr_i & sel_capt_s;
   wire wr_stat_s  = reg_wr_i & sel_stat_s;

   wire clr_ovf_s  = wr_stat_s & reg_wdata_i[STAT_OVF_BIT];
   wire clr_capt_s = wr_stat_s & reg_wdata_i[STAT_CAPT_BIT];

   logic [DATA_W-1:0] stat_s;

   always_comb begin
      stat_s                = '0;
      stat_s[STAT_OVF_BIT]  = ovf_q;
      stat_s[STAT_CAPT_BIT] = cflag_q;
   end

   // unused control bits 9 and 11 store nothing and read zero
   assign ctrl_d = wr_ctrl_s ? aux_ctrl_type'(reg_wdata_i & CTRL_WMASK)
                             : ctrl_q;

   assign rdata_d = !reg_rd_i   ? READ_IDLE :
                    sel_ctrl_s  ? DATA_W'(ctrl_q) :
                    sel_timer_s ? timer_q :
                    sel_capt_s  ? capt_q :
                    sel_stat_s  ? stat_s : READ_IDLE;

   aux_mode_type mode_s;
   logic         step_src_s;

   assign mode_s = aux_mode_type'(ctrl_q.aux_mode_field);

   // divider of 4 * 2^select from a free running prescaler
   wire tick_s = presc_tick(presc_q, ctrl_q.aux_input_select);

   // gate level chosen by low mode bit, gate is the count pin
   wire gate_open_s = ctrl_q.aux_mode_field[0] ? aux_count_pin_i
                                               : ~aux_count_pin_i;

   // pin edges or concatenation via core toggle latch
   wire cnt_evt_s = ctrl_q.aux_input_select[2]
                  ? edge_hit(ctrl_q.aux_input_select[1:0],
                             tog_edge_s.rise, tog_edge_s.fall)
                  : edge_hit(ctrl_q.aux_input_select[1:0],
                             pin_edge_s.rise, pin_edge_s.fall);

   always_comb begin
      step_src_s = 1'b0;
      unique case (mode_s)
         MODE_TIMER: begin
            step_src_s = tick_s;
         end
         MODE_COUNTER: begin
            step_src_s = cnt_evt_s;
         end
         MODE_GATE_LOW, MODE_GATE_HIGH: begin
            step_src_s = tick_s & gate_open_s;
         end
         default: begin
            step_src_s = 1'b0;
         end
      endcase
   end

   wire step_s = ctrl_q.aux_run_bit & step_src_s;

   // external pin inverts the programmed direction when enabled
   wire down_s = ctrl_q.aux_up_down_bit ^
                 (ctrl_q.aux_ext_direction_enable & aux_direction_pin_i);

   wire wrap_s = step_s & (down_s ? (timer_q == '0) : (&timer_q));

   // source bit picks capture pin or third timer inputs
   wire cap_trig_s = ctrl_q.capture_source_select
                   ? edge_hit(ctrl_q.capture_edge_select,
                              t3_count_any_s, t3_dir_any_s)
                   : edge_hit(ctrl_q.capture_edge_select,
                              cap_edge_s.rise, cap_edge_s.fall);

   wire cap_load_s = cap_trig_s & ctrl_q.capture_enable;
   wire cap_clr_s  = cap_trig_s & ctrl_q.clear_on_capture;

   // software write first, then clear on capture, then one step
   assign timer_d = wr_timer_s ? reg_wdata_i :
                    cap_clr_s  ? TIMER_RESET :
                    !step_s    ? timer_q :
                    down_s     ? timer_q - 16'h0001 :
                                 timer_q + 16'h0001;

   // capture of the old value wins over a write in the same cycle
   assign capt_d = cap_load_s ? timer_q :
                   wr_capt_s  ? reg_wdata_i : capt_q;

   // hardware set wins over software clear
   assign ovf_d   = wrap_s | (ovf_q & ~clr_ovf_s);
   assign cflag_d = cap_trig_s | (cflag_q & ~clr_capt_s);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         ctrl_q  <= aux_ctrl_type'(CTRL_RESET);
         timer_q <= TIMER_RESET;
         capt_q  <= CAPT_RESET;
         presc_q <= PRESC_RESET;
         rdata_q <= READ_IDLE;
         ovf_q   <= 1'b0;
         cflag_q <= 1'b0;
         cevt_q  <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         timer_q <= timer_d;
         capt_q  <= capt_d;
         presc_q <= presc_q + 9'h001;
         rdata_q <= rdata_d;
         ovf_q   <= ovf_d;
         cflag_q <= cflag_d;
         cevt_q  <= cap_trig_s;
      end
   end

   // no toggle latch and no pin output function here
   assign reg_rdata_o          = rdata_q;
   assign aux_timer_o          = timer_q;
   assign capture_reload_reg_o = capt_q;
   assign aux_overflow_flag_o  = ovf_q;
   assign capture_flag_o       = cflag_q;
   assign capture_event_o      = cevt_q;

   default clocking cb @(posedge mclk_i);
   endclocking

   default disable iff (!nrst_i);

   wire quiet_s = !wr_timer_s && !cap_clr_s;

   property p_run_halt;
      !ctrl_q.aux_run_bit && quiet_s |=> $stable(timer_q);
   endproperty
   a_run_halt: assert property (p_run_halt)
      else $error("timer moved while run bit clear");

   property p_timer_step;
      mode_s == MODE_TIMER && ctrl_q.aux_run_bit && tick_s && quiet_s
         |=> timer_q != $past(timer_q);
   endproperty
   a_timer_step: assert property (p_timer_step)
      else $error("timer mode tick did not step the timer");

   property p_presc_four;
      (tick_s && ctrl_q.aux_input_select == 3'b000)
         ##1 (ctrl_q.aux_input_select == 3'b000) [*3] |=> tick_s;
   endproperty
   a_presc_four: assert property (p_presc_four)
      else $error("divide by four tick spacing wrong");

   property p_presc_gap;
      tick_s |=> !tick_s [*3];
   endproperty
   a_presc_gap: assert property (p_presc_gap)
      else $error("prescaler ticks closer than four clocks");

   property p_gate_closed;
      (mode_s == MODE_GATE_LOW || mode_s == MODE_GATE_HIGH)
         && !gate_open_s && quiet_s |=> $stable(timer_q);
   endproperty
   a_gate_closed: assert property (p_gate_closed)
      else $error("gated timer counted with gate inactive");

   property p_pin_count;
      mode_s == MODE_COUNTER && ctrl_q.aux_run_bit
         && ctrl_q.aux_input_select == 3'b011
         && $changed(aux_count_pin_i) && quiet_s
         |=> timer_q != $past(timer_q);
   endproperty
   a_pin_count: assert property (p_pin_count)
      else $error("count pin transition missed");

   property p_sw_toggle;
      mode_s == MODE_COUNTER && ctrl_q.aux_input_select[2]
         && !core_toggle_hw_i && quiet_s |=> $stable(timer_q);
   endproperty
   a_sw_toggle: assert property (p_sw_toggle)
      else $error("unqualified toggle latch change counted");

   property p_clear;
      cap_trig_s && ctrl_q.clear_on_capture && !wr_timer_s
         |=> timer_q == 16'h0000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("timer not cleared on capture");

   property p_capture;
      cap_trig_s && ctrl_q.capture_enable |=> capt_q == $past(timer_q);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture register did not take timer value");

   property p_no_capture;
      !cap_load_s && !wr_capt_s |=> $stable(capt_q);
   endproperty
   a_no_capture: assert property (p_no_capture)
      else $error("capture register changed without trigger");

   property p_edge_off;
      ctrl_q.capture_edge_select == 2'b00 |-> !cap_trig_s ##1 !cevt_q;
   endproperty
   a_edge_off: assert property (p_edge_off)
      else $error("capture fired with edge field zero");

   property p_wrap;
      wrap_s |=> ovf_q && (timer_q == 16'h0000 || timer_q == 16'hFFFF
                           || $past(wr_timer_s) || $past(cap_clr_s));
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap did not raise overflow flag");

   property p_down;
      step_s && down_s && quiet_s |=> timer_q == $past(timer_q) - 16'h0001;
   endproperty
   a_down: assert property (p_down)
      else $error("down step did not decrement");

   property p_write;
      wr_timer_s |=> timer_q == $past(reg_wdata_i);
   endproperty
   a_write: assert property (p_write)
      else $error("timer write lost");

   property p_reset_ctrl;
      $rose(nrst_i) |-> ctrl_q == aux_ctrl_type'(CTRL_RESET);
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl)
      else $error("control register not zero after reset");

   property p_concat_count;
      mode_s == MODE_COUNTER && ctrl_q.aux_input_select == 3'b111
         && ctrl_q.aux_run_bit && tog_edge_s.rise;
   endproperty
   c_concat_count: cover property (p_concat_count);

   property p_capture_clear;
      cap_load_s && cap_clr_s;
   endproperty
   c_capture_clear: cover property (p_capture_clear);

   property p_overflow;
      wrap_s ##1 ovf_q;
   endproperty
   c_overflow: cover property (p_overflow);

   property p_gate_stop;
      mode_s == MODE_GATE_HIGH && ctrl_q.aux_run_bit && tick_s
         && !gate_open_s;
   endproperty
   c_gate_stop: cover property (p_gate_stop);

endmodule : aux_timer_control

`default_nettype wire

// file: tb/aux_pin_source.sv
// pin stimulus model for the auxiliary timer inputs
`timescale 1ns/10ps
`default_nettype none

module aux_pin_source (
   input  wire logic mclk_i,
   output logic      count_pin_o,
   output logic      dir_pin_o,
   output logic      capt_pin_o,
   output logic      t3_count_o,
   output logic      t3_dir_o,
   output logic      toggle_o,
   output logic      toggle_hw_o
);
   initial begin
      {count_pin_o, dir_pin_o, capt_pin_o, t3_count_o} = 4'h0;
      {t3_dir_o, toggle_o, toggle_hw_o} = 3'h0;
   end

   // lane 0 count, 1 capture, 2/3 third timer, else direction
   task automatic flip(input int lane);
      @(posedge mclk_i);
      case (lane)
         0: count_pin_o <= ~count_pin_o;
         1: capt_pin_o <= ~capt_pin_o;
         2: t3_count_o <= ~t3_count_o;
         3: t3_dir_o <= ~t3_dir_o;
         default: dir_pin_o <= ~dir_pin_o;
      endcase
      repeat (4) @(posedge mclk_i);
   endtask : flip

   // hw low marks a software change of the latch
   task automatic latch(input logic hw);
      @(posedge mclk_i);
      toggle_o <= ~toggle_o;
      toggle_hw_o <= hw;
      @(posedge mclk_i);
      toggle_hw_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask : latch
endmodule : aux_pin_source
`default_nettype wire

// file: tb/tb_aux_timer_control.sv
// self-checking bench of the auxiliary timer block
`timescale 1ns/10ps
`default_nettype none

module tb_aux_timer_control;
   import aux_timer_pkg::*;
   localparam logic [9:0] RUN = 10'h001;
   localparam logic [9:0] UD  = 10'h002;
   localparam logic [9:0] UDE = 10'h004;
   localparam logic [9:0] SRC = 10'h010;
   localparam logic [9:0] CLR = 10'h100;
   localparam logic [9:0] CEN = 10'h200;
   logic        mclk_i, nrst_i, wr, rd, h, tr, cl, ce;
   logic [15:0] addr, wdata, rdata, a, b, v, w;
   wire  logic  kp, dp, cp, tc, td, tl, th;
   wire  logic  ovf, cfl, cev;
   wire  logic [15:0] tmr, capr;
   int          mismatches, total_checks, seed, n, c, evts;

   aux_pin_source i_src (.mclk_i(mclk_i), .count_pin_o(kp),
      .dir_pin_o(dp), .capt_pin_o(cp), .t3_count_o(tc),
      .t3_dir_o(td), .toggle_o(tl), .toggle_hw_o(th));

   aux_timer_control i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .aux_count_pin_i(kp),
      .aux_direction_pin_i(dp), .capture_pin_i(cp),
      .third_timer_count_input_i(tc),
      .third_timer_direction_input_i(td),
      .core_toggle_latch_i(tl), .core_toggle_hw_i(th),
      .aux_timer_o(tmr), .capture_reload_reg_o(capr),
      .aux_overflow_flag_o(ovf), .capture_flag_o(cfl),
      .capture_event_o(cev));

   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // count one-cycle capture event pulses
   always @(posedge mclk_i) begin
      if (cev === 1'b1) evts++;
   end

   function automatic logic [15:0] mk(input logic [9:0] hi,
      input logic [2:0] m, input logic [2:0] s);
      return {hi, m, s};
   endfunction : mk

   task automatic wr_reg(input logic [15:0] ad, input logic [15:0] d);
      @(posedge mclk_i);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [15:0] ad, output logic [15:0] d);
      @(posedge mclk_i);
      addr <= ad;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rchk(input logic [15:0] ad, input logic [15:0] e,
      input string nm);
      logic [15:0] g;
      rd_reg(ad, g);
      chk(nm, e, g);
   endtask : rchk

   // timer change over three prescaler periods of select s
   task automatic span(input int s, output logic [15:0] d);
      rd_reg(TIMER_ADDR, a);
      repeat ((4 << s) * 3 - 2) @(posedge mclk_i);
      rd_reg(TIMER_ADDR, b);
      d = b - a;
   endtask : span

   task automatic done(input string nm);
      $display("test %s done, mismatches %0d", nm, mismatches);
   endtask : done

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge mclk_i);
      mismatches++;
      $display("watchdog expired");
      final_report;
   end

   initial begin
      seed = 32'h9E84;
      {nrst_i, wr, rd} = 3'h0;
      addr = 16'h0000;
      wdata = 16'h0000;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rchk(CTRL_ADDR, 16'h0000, "ctrl reset");
      rchk(STAT_ADDR, 16'h0000, "status reset");
      wr_reg(CTRL_ADDR, 16'hFFFF);
      rchk(CTRL_ADDR, 16'hF5FF, "ctrl bits");
      rchk(16'hFF50, 16'h0000, "unmapped");
      v = 16'($random(seed));
      wr_reg(TIMER_ADDR, v);
      i_src.flip(0);
      rchk(TIMER_ADDR, v, "timer rw");
      chk("timer out", v, tmr);
      done("registers");
      for (int s = 0; s < 8; s++) begin
         wr_reg(TIMER_ADDR, 16'h8000);
         wr_reg(CTRL_ADDR, mk(RUN | (s[0] ? UD : 10'h0), 3'd0, 3'(s)));
         span(s, w);
         chk("prescale", s[0] ? 16'hFFFD : 16'h0003, w);
      end
      wr_reg(CTRL_ADDR, mk(10'h0, 3'd0, 3'd0));
      span(0, w);
      chk("stopped", 16'h0000, w);
      i_src.flip(4);
      wr_reg(CTRL_ADDR, mk(RUN | UDE, 3'd0, 3'd0));
      span(0, w);
      chk("ext down", 16'hFFFD, w);
      wr_reg(CTRL_ADDR, mk(RUN | UDE | UD, 3'd0, 3'd0));
      span(0, w);
      chk("ext up", 16'h0003, w);
      done("timer");
      for (int g = 0; g < 4; g++) begin
         if (g == 2) i_src.flip(0);
         wr_reg(CTRL_ADDR, mk(RUN, 3'(2 + g[0]), 3'd0));
         span(0, w);
         chk("gated", (g[0] == kp) ? 16'h0003 : 16'h0000, w);
      end
      done("gated");
      for (int s = 0; s < 8; s++) begin
         wr_reg(TIMER_ADDR, 16'h0000);
         wr_reg(CTRL_ADDR, mk(RUN, 3'd1, 3'(s)));
         c = 0;
         n = 2 + ($random(seed) & 7);
         repeat (n) begin
            h = s[2] ? 1'($random(seed)) : 1'b1;
            if (h && ((s[2] ? tl : kp) ? s[1] : s[0])) c++;
            if (s[2]) i_src.latch(h);
            else i_src.flip(0);
         end
         rchk(TIMER_ADDR, 16'(c), "counter");
         chk("counter out", 16'(c), tmr);
      end
      wr_reg(TIMER_ADDR, 16'h0000);
      wr_reg(CTRL_ADDR, mk(RUN | UD, 3'd1, 3'd3));
      i_src.flip(0);
      rchk(TIMER_ADDR, 16'hFFFF, "underflow");
      rchk(STAT_ADDR, 16'h0001, "wrap flag");
      chk("ovf out", 16'h0001, 16'(ovf));
      wr_reg(STAT_ADDR, 16'h0001);
      rchk(STAT_ADDR, 16'h0000, "flag clear");
      chk("ovf out clear", 16'h0000, 16'(ovf));
      wr_reg(CTRL_ADDR, mk(RUN, 3'd4, 3'd3));
      i_src.flip(0);
      rchk(TIMER_ADDR, 16'hFFFF, "reserved");
      wr_reg(CTRL_ADDR, mk(10'h0, 3'd1, 3'd3));
      i_src.flip(0);
      rchk(TIMER_ADDR, 16'hFFFF, "halted");
      done("counter");
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      i_src.flip(0);
      nrst_i <= 1'b1;
      rchk(CTRL_ADDR, 16'h0000, "ctrl rerun");
      rchk(TIMER_ADDR, 16'h0000, "timer rerun");
      chk("capt rerun", 16'h0000, capr);
      done("reset");
      for (int i = 0; i < 32; i++) begin
         v = 16'($random(seed));
         w = 16'($random(seed));
         cl = 1'($random(seed));
         ce = 1'($random(seed));
         wr_reg(TIMER_ADDR, v);
         wr_reg(CAPT_ADDR, w);
         wr_reg(CTRL_ADDR, mk((i[4] ? SRC : 10'h0) | (cl ? CLR : 10'h0)
            | (ce ? CEN : 10'h0) | (10'(i[3:2]) << 6), 3'd0, 3'd0));
         n = 1 + (i % 3);
         if (!i[4]) tr = (n == 1) && (cp ? i[3] : i[2]);
         else tr = (n == 2 && i[2]) || (n == 3 && i[3]);
         c = evts;
         i_src.flip(n);
         chk("capt event", 16'(c) + 16'(tr), 16'(evts));
         chk("capt out", (tr && ce) ? v : w, capr);
         chk("capt flag out", 16'(tr), 16'(cfl));
         rchk(CAPT_ADDR, (tr && ce) ? v : w, "capture");
         rchk(TIMER_ADDR, (tr && cl) ? 16'h0000 : v, "clear");
         rchk(STAT_ADDR, {14'h0, tr, 1'b0}, "capt flag");
         wr_reg(STAT_ADDR, 16'h0003);
      end
      done("capture");
      final_report;
   end
endmodule : tb_aux_timer_control
`default_nettype wire
